// file: rtl/can_channel.sv
// Purpose: One CAN channel: bit timing, error state, silent mode, filter.
// Assumes: Error counter and frame fields come from the core on sys_clk.
// Notes: Register read data stand one cycle after the read strobe.
// ==========================================================
// What this block does
// - Enabled, counter below 96: error active.
// - Counter reaching 96: error warning.
// - Counter reaching 128: error passive.
// - Counter above 255: bus off, controller off.
// - Disabled or sleeping channel reports inactive.
// - Silent mode: no frames, no acknowledge.
// - Channel reset reinitialises only this channel.
// - Prescaler accepts 1 to 256.
// - Phase one 1 to 8, two 2 to 8.
// - Propagation segment accepts 1 to 8.
// - Sync segment is always one quantum.
// - Segment one sum below 4 rejected.
// - Segment two equals phase two; sets sample.
// - Jump width 1 to 4, not rate.
// - Standard mask filter compares unmasked bits.
// - Code and mask 11 or 29 bits.
// - Block list inverts the filter result.
// - Range filter needs lower below upper.
//
// Strobed register access and the address map were decided locally.
module can_channel (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [8:0] err_count,
  input wire logic core_tx,
  input wire logic core_ack,
  input wire logic bus_idle,
  input wire logic id_valid,
  input wire logic [28:0] id_in,
  input wire logic id_ext,
  input wire logic can_rx,
  output logic can_tx,
  output logic rx_bit,
  output logic tq_pulse,
  output logic sample_pulse,
  output logic bit_start,
  output logic core_rst_n,
  output logic bus_off,
  output logic fwd_valid,
  output logic fwd
);
  // ==========================================================
  // Reset release
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ==========================================================
  // Receive pin synchroniser
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_bit <= 1'b1;
    end else begin
      rx_s1 <= can_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_bit <= rx_s3;
      end
    end
  end

  // ==========================================================
  // Register decode
  logic enable;
  logic silent;
  logic sleep;
  logic chan_rst;
  logic rejected;
  logic [8:0] presc;
  logic [3:0] prop;
  logic [3:0] ph1;
  logic [3:0] ph2;
  logic [2:0] sjw;
  logic cfg_ext;
  logic cfg_block;
  logic cfg_range;
  logic [28:0] code;
  logic [28:0] mask;
  logic [28:0] lo;
  logic [28:0] hi;
  can_chan_pkg::chan_state_e state;

  wire wr_ctrl = reg_wr && reg_addr == can_chan_pkg::REG_CTRL;
  wire wr_timing = reg_wr && reg_addr == can_chan_pkg::REG_TIMING;
  wire wr_fcfg = reg_wr && reg_addr == can_chan_pkg::REG_FCFG;
  wire wr_fcode = reg_wr && reg_addr == can_chan_pkg::REG_FCODE;
  wire wr_fmask = reg_wr && reg_addr == can_chan_pkg::REG_FMASK;
  wire wr_flo = reg_wr && reg_addr == can_chan_pkg::REG_FLO;
  wire wr_fhi = reg_wr && reg_addr == can_chan_pkg::REG_FHI;

  wire [8:0] w_presc = reg_wdata[can_chan_pkg::T_PRESC +: 9];
  wire [3:0] w_prop = reg_wdata[can_chan_pkg::T_PROP +: 4];
  wire [3:0] w_ph1 = reg_wdata[can_chan_pkg::T_PH1 +: 4];
  wire [3:0] w_ph2 = reg_wdata[can_chan_pkg::T_PH2 +: 4];
  wire [2:0] w_sjw = reg_wdata[can_chan_pkg::T_SJW +: 3];
  wire [4:0] w_tseg1 = {1'b0, w_prop} + {1'b0, w_ph1};

  wire ok_presc = w_presc >= can_chan_pkg::PRESC_MIN
                  && w_presc <= can_chan_pkg::PRESC_MAX;
  wire ok_ph = w_ph1 >= can_chan_pkg::SEG_MIN
               && w_ph1 <= can_chan_pkg::SEG_MAX
               && w_ph2 >= can_chan_pkg::PH2_MIN
               && w_ph2 <= can_chan_pkg::SEG_MAX;
  wire ok_prop = w_prop >= can_chan_pkg::SEG_MIN
                 && w_prop <= can_chan_pkg::SEG_MAX;
  wire ok_sjw = w_sjw >= can_chan_pkg::SJW_MIN
                && w_sjw <= can_chan_pkg::SJW_MAX;
  wire ok_tseg1 = w_tseg1 >= can_chan_pkg::TSEG1_MIN;
  wire timing_ok = ok_presc && ok_ph && ok_prop && ok_sjw && ok_tseg1;

  // ==========================================================
  // Control and timing registers
  // Channel reset pulse.
  wire next_chan_rst = wr_ctrl && reg_wdata[can_chan_pkg::CTRL_RST];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= 1'b0;
      silent <= 1'b0;
      sleep <= 1'b0;
      chan_rst <= 1'b0;
    end else begin
      chan_rst <= next_chan_rst;
      if (wr_ctrl) begin
        enable <= reg_wdata[can_chan_pkg::CTRL_EN];
        silent <= reg_wdata[can_chan_pkg::CTRL_SILENT];
        sleep <= reg_wdata[can_chan_pkg::CTRL_SLEEP];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc <= can_chan_pkg::PRESC_RST;
      prop <= can_chan_pkg::PROP_RST;
      ph1 <= can_chan_pkg::PH1_RST;
      ph2 <= can_chan_pkg::PH2_RST;
      sjw <= can_chan_pkg::SJW_RST;
      rejected <= 1'b0;
    end else if (wr_timing && timing_ok) begin
      presc <= w_presc;
      prop <= w_prop;
      ph1 <= w_ph1;
      ph2 <= w_ph2;
      sjw <= w_sjw;
      rejected <= 1'b0;
    end else if (wr_timing) begin
      // Invalid settings are dropped and flagged.
      rejected <= 1'b1;
    end else if (chan_rst) begin
      rejected <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ext <= 1'b0;
      cfg_block <= 1'b0;
      cfg_range <= 1'b0;
      code <= 29'h0000_0000;
      mask <= 29'h1fff_ffff;
      lo <= 29'h0000_0000;
      hi <= 29'h1fff_ffff;
    end else begin
      if (wr_fcfg) begin
        cfg_ext <= reg_wdata[can_chan_pkg::F_EXT];
        cfg_block <= reg_wdata[can_chan_pkg::F_BLOCK];
        cfg_range <= reg_wdata[can_chan_pkg::F_RANGE];
      end
      if (wr_fcode) code <= reg_wdata[28:0];
      if (wr_fmask) mask <= reg_wdata[28:0];
      if (wr_flo) lo <= reg_wdata[28:0];
      if (wr_fhi) hi <= reg_wdata[28:0];
    end
  end

  // ==========================================================
  // Error state
  // Severity order picks the reported state.
  wire running = enable && !sleep;
  wire st_busoff = err_count > can_chan_pkg::ERR_BUSOFF;
  wire st_passive = err_count >= can_chan_pkg::ERR_PASSIVE;
  wire st_warning = err_count >= can_chan_pkg::ERR_WARN;
  can_chan_pkg::chan_state_e next_state;
  always_comb begin
    if (!running) begin
      next_state = can_chan_pkg::ST_INACTIVE;
    end else if (st_busoff) begin
      next_state = can_chan_pkg::ST_BUS_OFF;
    end else if (st_passive) begin
      next_state = can_chan_pkg::ST_PASSIVE;
    end else if (st_warning) begin
      next_state = can_chan_pkg::ST_WARNING;
    end else begin
      next_state = can_chan_pkg::ST_ACTIVE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= can_chan_pkg::ST_INACTIVE;
      bus_off <= 1'b0;
      core_rst_n <= 1'b0;
    end else begin
      state <= next_state;
      bus_off <= running && st_busoff;
      core_rst_n <= !chan_rst && !next_chan_rst;
    end
  end

  // ==========================================================
  // Transmit gating
  // Silent, disabled or bus off keeps the line recessive.
  wire tx_allow = running && !silent && !st_busoff && !chan_rst;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      can_tx <= 1'b1;
    end else begin
      can_tx <= tx_allow ? (core_tx & ~core_ack) : 1'b1;
    end
  end

  // ==========================================================
  // Bit time and read port
  // Quanta per bit times prescaler.
  wire [4:0] tseg1 = {1'b0, prop} + {1'b0, ph1};
  wire [4:0] quanta = 5'h01 + tseg1 + {1'b0, ph2};
  wire [13:0] bit_len = 14'(presc) * 14'(quanta);

  wire [31:0] status_word = {15'h0000, err_count, 2'b00, rx_bit,
                             rejected, 1'b0, state};
  wire [31:0] timing_word = {5'h00, sjw, ph2, ph1, prop,
                             3'h0, presc};
  logic [31:0] next_rdata;
  always_comb begin
    if (reg_addr == can_chan_pkg::REG_CTRL) begin
      next_rdata = {28'h000_0000, 1'b0, sleep, silent, enable};
    end else if (reg_addr == can_chan_pkg::REG_TIMING) begin
      next_rdata = timing_word;
    end else if (reg_addr == can_chan_pkg::REG_STATUS) begin
      next_rdata = status_word;
    end else if (reg_addr == can_chan_pkg::REG_FCFG) begin
      next_rdata = {29'h0000_0000, cfg_range, cfg_block, cfg_ext};
    end else if (reg_addr == can_chan_pkg::REG_FCODE) begin
      next_rdata = {3'h0, code};
    end else if (reg_addr == can_chan_pkg::REG_FMASK) begin
      next_rdata = {3'h0, mask};
    end else if (reg_addr == can_chan_pkg::REG_FLO) begin
      next_rdata = {3'h0, lo};
    end else if (reg_addr == can_chan_pkg::REG_FHI) begin
      next_rdata = {3'h0, hi};
    end else if (reg_addr == can_chan_pkg::REG_BITLEN) begin
      next_rdata = {18'h0_0000, bit_len};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Timer and filter
  // Channel reset restarts timing and filter.
  wire restart = chan_rst || !running;
  quantum_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(restart),
    .presc(presc),
    .tseg1(tseg1),
    .tseg2(ph2),
    .sjw(sjw),
    .rx_bit(rx_bit),
    .bus_idle(bus_idle),
    .tq_pulse(tq_pulse),
    .sample_pulse(sample_pulse),
    .bit_start(bit_start)
  );

  // Silent mode still receives and filters.
  id_filter u_filter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear(restart),
    .id_valid(id_valid),
    .id_in(id_in),
    .id_ext(id_ext),
    .cfg_ext(cfg_ext),
    .cfg_block(cfg_block),
    .cfg_range(cfg_range),
    .code(code),
    .mask(mask),
    .lo(lo),
    .hi(hi),
    .fwd_valid(fwd_valid),
    .fwd(fwd)
  );

  // ==========================================================
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_active_state: assert property (
    (running && err_count < 9'h060)
    |=> state == can_chan_pkg::ST_ACTIVE)
    else $error("low count not reported as active");
  chk_warning_state: assert property (
    (running && err_count >= 9'h060 && err_count < 9'h080)
    |=> state == can_chan_pkg::ST_WARNING)
    else $error("count 96 to 127 not reported as warning");
  chk_passive_state: assert property (
    (running && err_count >= 9'h080 && err_count <= 9'h0ff)
    |=> state == can_chan_pkg::ST_PASSIVE)
    else $error("count 128 to 255 not reported as passive");
  chk_bus_off: assert property (
    (running && err_count > 9'h0ff)
    |=> state == can_chan_pkg::ST_BUS_OFF && bus_off && can_tx)
    else $error("bus off not reported or line driven");
  chk_inactive_state: assert property (
    (!enable || sleep) |=> state == can_chan_pkg::ST_INACTIVE && can_tx)
    else $error("idle channel not reported inactive");
  chk_silent_tx: assert property (
    silent |=> can_tx)
    else $error("silent channel drove the line");
  chk_short_reject: assert property (
    (wr_timing && w_tseg1 < 5'h04)
    |=> rejected && $stable(prop) && $stable(ph1) && $stable(presc))
    else $error("short segment one accepted");
  chk_presc_reject: assert property (
    (wr_timing && (w_presc == 9'h000 || w_presc > 9'h100))
    |=> rejected && $stable(presc))
    else $error("prescaler out of range accepted");
  chk_chan_reset: assert property (
    next_chan_rst |=> !core_rst_n ##1 !core_rst_n && !tq_pulse)
    else $error("channel reset not applied");
  chk_read_latency: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside the read slot");
endmodule

// file: rtl/can_chan_pkg.sv
// Purpose: Shared constants for the CAN channel timing and filter block.
// Assumes: One 10 MHz controller clock, 32-bit register port.
// Notes: Offsets are word indices on the plain register port.
package can_chan_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TIMING = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_FCFG = 4'h3;
  localparam logic [3:0] REG_FCODE = 4'h4;
  localparam logic [3:0] REG_FMASK = 4'h5;
  localparam logic [3:0] REG_FLO = 4'h6;
  localparam logic [3:0] REG_FHI = 4'h7;
  localparam logic [3:0] REG_BITLEN = 4'h8;
  // ==========================================================
  // Field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_SILENT = 1;
  localparam int CTRL_SLEEP = 2;
  localparam int CTRL_RST = 3;
  localparam int T_PRESC = 0;
  localparam int T_PROP = 12;
  localparam int T_PH1 = 16;
  localparam int T_PH2 = 20;
  localparam int T_SJW = 24;
  localparam int F_EXT = 0;
  localparam int F_BLOCK = 1;
  localparam int F_RANGE = 2;
  localparam int S_REJECT = 4;
  localparam int S_RX = 5;
  localparam int S_ERR = 8;
  // ==========================================================
  // Limits and reset values
  localparam logic [8:0] PRESC_MIN = 9'h001;
  localparam logic [8:0] PRESC_MAX = 9'h100;
  localparam logic [3:0] SEG_MIN = 4'h1;
  localparam logic [3:0] SEG_MAX = 4'h8;
  localparam logic [3:0] PH2_MIN = 4'h2;
  localparam logic [2:0] SJW_MIN = 3'h1;
  localparam logic [2:0] SJW_MAX = 3'h4;
  localparam logic [4:0] TSEG1_MIN = 5'h04;
  localparam logic [8:0] PRESC_RST = 9'h002;
  localparam logic [3:0] PROP_RST = 4'h3;
  localparam logic [3:0] PH1_RST = 4'h2;
  localparam logic [3:0] PH2_RST = 4'h2;
  localparam logic [2:0] SJW_RST = 3'h1;
  localparam logic [8:0] ERR_WARN = 9'h060;
  localparam logic [8:0] ERR_PASSIVE = 9'h080;
  localparam logic [8:0] ERR_BUSOFF = 9'h0ff;
  typedef enum logic [2:0] {
    ST_INACTIVE, ST_ACTIVE, ST_WARNING, ST_PASSIVE, ST_BUS_OFF
  } chan_state_e;
endpackage

// file: rtl/quantum_timer.sv
// Purpose: Time quantum divider and bit segment sequencer.
// Assumes: Settings are already range checked by the caller.
// Notes: Edges are taken at the next quantum boundary.
module quantum_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [8:0] presc,
  input wire logic [4:0] tseg1,
  input wire logic [3:0] tseg2,
  input wire logic [2:0] sjw,
  input wire logic rx_bit,
  input wire logic bus_idle,
  output logic tq_pulse,
  output logic sample_pulse,
  output logic bit_start
);
  // ==========================================================
  // Quantum divider and edge capture
  logic [8:0] presc_cnt;
  logic [4:0] pos;
  logic [2:0] hold;
  logic rx_prev;
  logic edge_pend;
  wire tq = (presc_cnt == presc - 9'h001);
  wire fall = rx_prev & ~rx_bit;
  // Sync segment of one quantum plus both time segments.
  wire [4:0] nbit = 5'h01 + tseg1 + {1'b0, tseg2};
  wire [4:0] rem = nbit - 5'h01 - pos;
  wire in_tseg1 = (pos != 5'h00) && (pos <= tseg1);
  wire [2:0] lengthen = (pos < {2'b00, sjw}) ? pos[2:0] : sjw;
  wire last = (pos == nbit - 5'h01);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt <= 9'h000;
      rx_prev <= 1'b1;
      edge_pend <= 1'b0;
    end else if (restart) begin
      presc_cnt <= 9'h000;
      rx_prev <= 1'b1;
      edge_pend <= 1'b0;
    end else begin
      presc_cnt <= tq ? 9'h000 : presc_cnt + 9'h001;
      rx_prev <= rx_bit;
      edge_pend <= fall | (edge_pend & ~tq);
    end
  end

  // ==========================================================
  // Segment position with resynchronisation
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 5'h00;
      hold <= 3'h0;
    end else if (restart) begin
      pos <= 5'h00;
      hold <= 3'h0;
    end else if (tq) begin
      if (edge_pend && bus_idle) begin
        pos <= 5'h01;
        hold <= 3'h0;
      end else if (edge_pend && in_tseg1 && hold == 3'h0) begin
        hold <= lengthen;
        pos <= pos + 5'h01;
      end else if (edge_pend && !in_tseg1 && pos != 5'h00) begin
        pos <= (rem <= {2'b00, sjw}) ? 5'h00 : pos + {2'b00, sjw} + 5'h01;
      end else if (hold != 3'h0) begin
        hold <= hold - 3'h1;
      end else begin
        pos <= last ? 5'h00 : pos + 5'h01;
      end
    end
  end

  // Sample point at end of segment one.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tq_pulse <= 1'b0;
      sample_pulse <= 1'b0;
      bit_start <= 1'b0;
    end else begin
      tq_pulse <= tq & ~restart;
      sample_pulse <= tq & ~restart & ~edge_pend & hold == 3'h0
                      & pos == tseg1;
      bit_start <= tq & ~restart & ~edge_pend & hold == 3'h0 & last;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_quantum_spacing: assert property (
    (tq_pulse && presc == 9'h002 && !restart && $stable(presc))
    |=> !tq_pulse ##1 (tq_pulse || $past(restart)))
    else $error("quantum spacing wrong for prescaler two");
endmodule

// file: rtl/id_filter.sv
// Purpose: Identifier acceptance filter with mask and range types.
// Assumes: Identifier arrives with a one-cycle valid strobe.
// Notes: Data bytes and the remote flag never reach this logic.
module id_filter (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic id_valid,
  input wire logic [28:0] id_in,
  input wire logic id_ext,
  input wire logic cfg_ext,
  input wire logic cfg_block,
  input wire logic cfg_range,
  input wire logic [28:0] code,
  input wire logic [28:0] mask,
  input wire logic [28:0] lo,
  input wire logic [28:0] hi,
  output logic fwd_valid,
  output logic fwd
);
  // ==========================================================
  // Match logic
  // Width follows identifier mode.
  wire [28:0] width_mask = cfg_ext ? 29'h1fff_ffff : 29'h0000_07ff;
  wire [28:0] idw = id_in & width_mask;
  // Clear mask bits must equal the code.
  wire [28:0] diff = (idw ^ (code & width_mask)) & ~mask & width_mask;
  wire mask_hit = (diff == 29'h0000_0000);
  wire [28:0] low = lo & width_mask;
  wire [28:0] high = hi & width_mask;
  // Range needs lower limit below upper.
  wire range_hit = (low < high) && (idw >= low) && (idw <= high);
  wire hit = (id_ext == cfg_ext) && (cfg_range ? range_hit : mask_hit);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid <= 1'b0;
      fwd <= 1'b0;
    end else begin
      fwd_valid <= id_valid & ~clear;
      fwd <= (id_valid & ~clear) ? hit ^ cfg_block : 1'b0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_mask_accept: assert property (
    (id_valid && !clear && !id_ext && !cfg_ext && !cfg_range
     && !cfg_block && ((id_in ^ code) & ~mask & 29'h0000_07ff) == 0)
    |=> fwd_valid && fwd)
    else $error("matching standard identifier not forwarded");
  chk_block_invert: assert property (
    (id_valid && !clear && cfg_block && id_ext != cfg_ext)
    |=> fwd_valid && fwd)
    else $error("block list did not invert a miss");
endmodule

// file: test/can_node.sv
// Purpose: Other node on the CAN bus, wired with the channel.
// Assumes: Recessive is 1, and any node driving 0 wins the bus.
// Notes: The node drives dominant only when the bench tells it to.
module can_node (
  input wire logic can_tx,
  input wire logic node_dom,
  output logic can_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Bus level
  assign can_rx = can_tx & ~node_dom;
endmodule

// file: test/tb_can_channel.sv
// Purpose: Self-checking bench for the CAN channel block.
// Assumes: 10 MHz clock and one other node on the bus.
// Notes: Error states and rejected timings run from tables, the rest by hand.
module tb_can_channel;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [8:0] cnt; logic [2:0] st;} row_s;
  row_s rows [8] = '{'{9'h000, 3'h1}, '{9'h05f, 3'h1}, '{9'h060, 3'h2},
    '{9'h07f, 3'h2}, '{9'h080, 3'h3}, '{9'h0ff, 3'h3}, '{9'h100, 3'h4},
    '{9'h1ff, 3'h4}};
  logic [31:0] bad [11] = '{32'h0122_3000, 32'h0122_3101, 32'h0122_0002,
    32'h0122_9002, 32'h0120_3002, 32'h0129_3002, 32'h0112_3002,
    32'h0192_3002, 32'h0022_3002, 32'h0522_3002, 32'h0122_1002};
  logic sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, node_dom = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rd;
  logic [8:0] err_count = 9'h000;
  logic core_tx = 1, core_ack = 0, bus_idle = 0, id_valid = 0, id_ext = 0;
  logic [28:0] id_in = 29'h0000_0000;
  logic can_rx, can_tx, rx_bit, tq_pulse, sample_pulse, bit_start;
  logic core_rst_n, bus_off, fwd_valid, fwd;
  int fails = 0, tests_run = 0, n;
  can_channel i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_count(err_count),
    .core_tx(core_tx), .core_ack(core_ack), .bus_idle(bus_idle),
    .id_valid(id_valid), .id_in(id_in), .id_ext(id_ext), .can_rx(can_rx),
    .can_tx(can_tx), .rx_bit(rx_bit), .tq_pulse(tq_pulse),
    .sample_pulse(sample_pulse), .bit_start(bit_start),
    .core_rst_n(core_rst_n), .bus_off(bus_off), .fwd_valid(fwd_valid),
    .fwd(fwd));
  can_node i_node (.can_tx(can_tx), .node_dom(node_dom), .can_rx(can_rx));
  // ==========================================================
  // Clock and tasks
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdreg(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic idchk(input logic [28:0] id, input logic ext, input logic e);
    @(posedge sys_clk);
    id_valid <= 1'b1;
    id_in <= id;
    id_ext <= ext;
    @(posedge sys_clk);
    id_valid <= 1'b0;
    #1 check(fwd_valid, 1);
    check(fwd, e);
  endtask
  task automatic until1(ref logic s, output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
    end while (s !== 1'b1 && k < 300);
  endtask
  task automatic end_sim;
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    fails++;
    end_sim();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdreg(can_chan_pkg::REG_TIMING);
    check(rd, 32'h0122_3002);
    rdreg(can_chan_pkg::REG_BITLEN);
    check(rd, 32'h0000_0010);
    rdreg(can_chan_pkg::REG_STATUS);
    check(rd[2:0], 0);
    wr(can_chan_pkg::REG_CTRL, 32'h0000_0001);
    core_tx <= 1'b0;
    foreach (rows[i]) begin
      err_count <= rows[i].cnt;
      rdreg(can_chan_pkg::REG_STATUS);
      check(rd[2:0], rows[i].st);
      check(rd[16:8], rows[i].cnt);
      check(bus_off, rows[i].st == 3'h4);
      check(can_tx, rows[i].st == 3'h4);
    end
    err_count <= 9'h000;
    wr(can_chan_pkg::REG_CTRL, 32'h0000_0005);
    rdreg(can_chan_pkg::REG_STATUS);
    check(rd[2:0], 0);
    wr(can_chan_pkg::REG_CTRL, 32'h0000_0003);
    core_ack <= 1'b1;
    node_dom <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 check(can_tx, 1);
    check(rx_bit, 0);
    core_tx <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check(can_tx, 1);
    node_dom <= 1'b0;
    wr(can_chan_pkg::REG_CTRL, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    #1 check(can_tx, 0);
    core_ack <= 1'b0;
    foreach (bad[i]) begin
      wr(can_chan_pkg::REG_TIMING, bad[i]);
      rdreg(can_chan_pkg::REG_STATUS);
      check(rd[4], 1);
      rdreg(can_chan_pkg::REG_TIMING);
      check(rd, 32'h0122_3002);
    end
    wr(can_chan_pkg::REG_CTRL, 32'h0000_0009);
    n = 0;
    #1 n += (core_rst_n === 1'b0);
    repeat (6) begin
      @(posedge sys_clk);
      #1 n += (core_rst_n === 1'b0);
    end
    check(n, 2);
    rdreg(can_chan_pkg::REG_STATUS);
    check(rd[4], 0);
    rdreg(can_chan_pkg::REG_CTRL);
    check(rd, 32'h0000_0001);
    wr(can_chan_pkg::REG_TIMING, 32'h0483_1002);
    rdreg(can_chan_pkg::REG_BITLEN);
    check(rd, 32'h0000_001a);
    until1(bit_start, n);
    until1(sample_pulse, n);
    check(n, 10);
    until1(bit_start, n);
    check(n, 16);
    until1(bit_start, n);
    check(n, 26);
    until1(sample_pulse, n);
    node_dom <= 1'b1;
    until1(bit_start, n);
    check(n, 8);
    node_dom <= 1'b0;
    until1(bit_start, n);
    check(n, 26);
    bus_idle <= 1'b1;
    node_dom <= 1'b1;
    until1(bit_start, n);
    check(n, 30);
    bus_idle <= 1'b0;
    node_dom <= 1'b0;
    wr(can_chan_pkg::REG_FCODE, 32'h0000_03df);
    wr(can_chan_pkg::REG_FMASK, 32'h0000_070d);
    wr(can_chan_pkg::REG_FLO, 32'h0000_0010);
    wr(can_chan_pkg::REG_FHI, 32'h0000_0020);
    idchk(29'h0d2, 1'b0, 1'b1);
    idchk(29'h7d2, 1'b0, 1'b1);
    idchk(29'h0d0, 1'b0, 1'b0);
    idchk(29'h0d2, 1'b1, 1'b0);
    wr(can_chan_pkg::REG_FCFG, 32'h0000_0002);
    idchk(29'h0d2, 1'b0, 1'b0);
    idchk(29'h0d0, 1'b0, 1'b1);
    idchk(29'h0d2, 1'b1, 1'b1);
    wr(can_chan_pkg::REG_FCFG, 32'h0000_0004);
    idchk(29'h015, 1'b0, 1'b1);
    idchk(29'h021, 1'b0, 1'b0);
    wr(can_chan_pkg::REG_FCFG, 32'h0000_0005);
    idchk(29'h020, 1'b1, 1'b1);
    wr(can_chan_pkg::REG_FLO, 32'h0000_0020);
    idchk(29'h020, 1'b1, 1'b0);
    end_sim();
  end
endmodule
